// *** design/sawr_station_regs.v ***
// node/alias address, write protection and network reset sequence bank
`timescale 1ns/1ps
`default_nettype none
`include "sawr_defines.vh"

module sawr_station_regs #(
  parameter AW = 16
) (
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          sof,
  input  wire          alias_en,
  input  wire          net_wr,
  input  wire          net_rd,
  input  wire [AW-1:0] net_addr,
  input  wire [7:0]    net_wdata,
  output reg  [7:0]    net_rdata,
  output reg           net_wr_ok,
  output reg           net_wr_refused,
  input  wire          host_wr,
  input  wire          host_rd,
  input  wire [AW-1:0] host_addr,
  input  wire [7:0]    host_wdata,
  output reg  [7:0]    host_rdata,
  input  wire          nvm_load,
  input  wire [15:0]   nvm_alias,
  input  wire          cmd_valid,
  input  wire [15:0]   cmd_addr,
  output reg           cmd_match,
  output reg           reset_req,
  output reg           reg_protect_bit,
  output reg           device_protect_bit
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  reg [15:0] node_addr_field_q;
  reg [15:0] node_addr_field_d;
  reg [15:0] alias_addr_field_q;
  reg [15:0] alias_addr_field_d;
  reg        reg_enable_q;
  reg        reg_enable_d;
  reg        reg_protect_q;
  reg        reg_protect_d;
  reg        device_enable_bit_q;
  reg        device_enable_bit_d;
  reg        dev_protect_q;
  reg        dev_protect_d;
  reg [1:0]  prog_q;
  reg [1:0]  prog_d;
  reg        prog_adv_q;
  reg        prog_adv_d;
  reg        nvm_done_q;
  reg        nvm_done_d;
  reg        reset_d;

  // ---------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------
  // read value of any offset, shared by both sides
  function [7:0] rd_mux;
    input [AW-1:0] a;
    begin
      case (a)
        `SAWR_OFS_NODE_LO:  rd_mux = node_addr_field_q[7:0];
        `SAWR_OFS_NODE_HI:  rd_mux = node_addr_field_q[15:8];
        `SAWR_OFS_ALIAS_LO: rd_mux = alias_addr_field_q[7:0];
        `SAWR_OFS_ALIAS_HI: rd_mux = alias_addr_field_q[15:8];
        `SAWR_OFS_REG_WEN:  rd_mux = {7'h00, reg_enable_q};
        `SAWR_OFS_REG_WP:   rd_mux = {7'h00, reg_protect_q};
        `SAWR_OFS_DEV_WEN:  rd_mux = {7'h00, device_enable_bit_q};
        `SAWR_OFS_DEV_WP:   rd_mux = {7'h00, dev_protect_q};
        `SAWR_OFS_NET_RST:  rd_mux = {6'h00, prog_q};
        default:            rd_mux = `SAWR_RST_BYTE;
      endcase
    end
  endfunction

  // true when a network write to this offset must be refused
  function refused;
    input [AW-1:0] a;
    input          rp;
    input          ren;
    input          dp;
    input          den;
    reg            in_area;
    begin
      in_area = (a <= `SAWR_REG_AREA_LAST) && (a != `SAWR_OFS_REG_WEN) &&
                (a != `SAWR_OFS_DEV_WEN);
      refused = (dp && !den && (a != `SAWR_OFS_DEV_WEN)) ||
                (rp && !ren && in_area);
    end
  endfunction

  // ---------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------
  wire net_refuse = net_wr && refused(net_addr, reg_protect_q, reg_enable_q,
                                      dev_protect_q, device_enable_bit_q);
  wire net_take   = net_wr && !net_refuse;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always @* begin
    node_addr_field_d   = node_addr_field_q;
    alias_addr_field_d  = alias_addr_field_q;
    reg_enable_d        = reg_enable_q;
    reg_protect_d       = reg_protect_q;
    device_enable_bit_d = device_enable_bit_q;
    dev_protect_d       = dev_protect_q;
    prog_d              = prog_q;
    prog_adv_d          = prog_adv_q;
    nvm_done_d          = nvm_done_q;
    reset_d             = 1'b0;

    // frame boundary: enables drop, stalled sequence is abandoned
    if (sof) begin
      reg_enable_d        = 1'b0;
      device_enable_bit_d = 1'b0;
      prog_adv_d          = 1'b0;
      if (!prog_adv_q) begin
        prog_d = `SAWR_PRG_IDLE;
      end
    end

    // alias from nonvolatile memory, first load only
    if (nvm_load && !nvm_done_q) begin
      alias_addr_field_d = nvm_alias;
      nvm_done_d         = 1'b1;
    end

    // host writes: only the alias is host-writable
    if (host_wr) begin
      case (host_addr)
        `SAWR_OFS_ALIAS_LO: alias_addr_field_d[7:0]  = host_wdata;
        `SAWR_OFS_ALIAS_HI: alias_addr_field_d[15:8] = host_wdata;
        default: ;
      endcase
    end

    // network writes that passed protection
    if (net_take) begin
      case (net_addr)
        `SAWR_OFS_NODE_LO: node_addr_field_d[7:0]  = net_wdata;
        `SAWR_OFS_NODE_HI: node_addr_field_d[15:8] = net_wdata;
        `SAWR_OFS_REG_WEN: reg_enable_d = 1'b1;
        `SAWR_OFS_REG_WP:  reg_protect_d = net_wdata[`SAWR_BIT_ENABLE];
        `SAWR_OFS_DEV_WEN: device_enable_bit_d = 1'b1;
        `SAWR_OFS_DEV_WP:  dev_protect_d = net_wdata[`SAWR_BIT_ENABLE];
        `SAWR_OFS_NET_RST: begin
          prog_adv_d = 1'b1;
          if (prog_adv_q) begin
            prog_d = `SAWR_PRG_IDLE;
          end else begin
            case (prog_q)
              `SAWR_PRG_IDLE: begin
                if (net_wdata == `SAWR_SEQ_BYTE1) begin
                  prog_d = `SAWR_PRG_ONE;
                end else begin
                  prog_d = `SAWR_PRG_IDLE;
                end
              end
              `SAWR_PRG_ONE: begin
                if (net_wdata == `SAWR_SEQ_BYTE2) begin
                  prog_d = `SAWR_PRG_TWO;
                end else begin
                  prog_d = `SAWR_PRG_IDLE;
                end
              end
              `SAWR_PRG_TWO: begin
                prog_d = `SAWR_PRG_IDLE;
                if (net_wdata == `SAWR_SEQ_BYTE3) begin
                  reset_d = 1'b1;
                end
              end
              default: prog_d = `SAWR_PRG_IDLE;
            endcase
          end
        end
        default: ;
      endcase
    end

    // protection off drops its enable, overriding any set
    if (!reg_protect_d) begin
      reg_enable_d = 1'b0;
    end
    if (!dev_protect_d) begin
      device_enable_bit_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      node_addr_field_q   <= `SAWR_RST_NODE;
      alias_addr_field_q  <= `SAWR_RST_ALIAS;
      reg_enable_q        <= 1'b0;
      reg_protect_q       <= 1'b0;
      device_enable_bit_q <= 1'b0;
      dev_protect_q       <= 1'b0;
      prog_q              <= `SAWR_PRG_IDLE;
      prog_adv_q          <= 1'b0;
      nvm_done_q          <= 1'b0;
      reset_req           <= 1'b0;
      net_rdata           <= `SAWR_RST_BYTE;
      host_rdata          <= `SAWR_RST_BYTE;
      net_wr_ok           <= 1'b0;
      net_wr_refused      <= 1'b0;
      cmd_match           <= 1'b0;
      reg_protect_bit     <= 1'b0;
      device_protect_bit  <= 1'b0;
    end else begin
      node_addr_field_q   <= node_addr_field_d;
      alias_addr_field_q  <= alias_addr_field_d;
      reg_enable_q        <= reg_enable_d;
      reg_protect_q       <= reg_protect_d;
      device_enable_bit_q <= device_enable_bit_d;
      dev_protect_q       <= dev_protect_d;
      prog_q              <= prog_d;
      prog_adv_q          <= prog_adv_d;
      nvm_done_q          <= nvm_done_d;
      reset_req           <= reset_d;
      net_rdata           <= net_rd ? rd_mux(net_addr) : `SAWR_RST_BYTE;
      host_rdata          <= host_rd ? rd_mux(host_addr) : `SAWR_RST_BYTE;
      net_wr_ok           <= net_take;
      net_wr_refused      <= net_refuse;
      cmd_match           <= cmd_valid &&
                             ((cmd_addr == node_addr_field_q) ||
                              (alias_en && (cmd_addr == alias_addr_field_q)));
      reg_protect_bit     <= reg_protect_d;
      device_protect_bit  <= dev_protect_d;
    end
  end

endmodule // sawr_station_regs

`default_nettype wire

// *** design/sawr_defines.vh ***
// register offsets, field positions and constants of the address/protection/reset bank
// Notes on behaviour
// - the node address is sixteen bits, zero after reset, written only by the network side, read-only to the host, and used to match configured-address commands.
// - the alias address is sixteen bits, zero after reset, written only by the host or the first nonvolatile memory load, read-only to the network side,
//   and used for matching only while alias enable is set.
// - with alias enable at one the alias matches every configured-address command type, with it at zero the alias is ignored.
// - the alias value from nonvolatile memory is taken only on the first configuration load after power-on or reset.
// - with register protection on, the master writes the register-enable register earlier in the same frame, and until then protected writes are refused.
// - the register-enable bit clears at the next start of frame and whenever register protection is switched off.
// - register protection is on while its bit is one and covers offsets 0x0000 to 0x0F7F except 0x0020 and 0x0030.
// - with device protection on, the master writes the device-enable register earlier in the same frame, and until then every other write is refused.
// - the device-enable bit clears at the next start of frame and whenever device protection is switched off.
// - device protection at one protects every address except the device-enable register.
// - the bytes 0x52, 0x45 and 0x53 written in that order to the reset register in three consecutive frames raise a reset.
// - a frame that does not continue the sequence with the next expected byte sends the progress back to the initial state.
// - reading the reset register gives the progress in bits 1:0, 00 at first, 01 after the first byte, 10 after the second.
// - the third byte in progress 10 raises the reset at once, so 11 is never seen and the progress goes back to 00.
`ifndef SAWR_DEFINES_VH
`define SAWR_DEFINES_VH

`define SAWR_OFS_NODE_LO   16'h0010
`define SAWR_OFS_NODE_HI   16'h0011
`define SAWR_OFS_ALIAS_LO  16'h0012
`define SAWR_OFS_ALIAS_HI  16'h0013
`define SAWR_OFS_REG_WEN   16'h0020
`define SAWR_OFS_REG_WP    16'h0021
`define SAWR_OFS_DEV_WEN   16'h0030
`define SAWR_OFS_DEV_WP    16'h0031
`define SAWR_OFS_NET_RST   16'h0040
`define SAWR_REG_AREA_LAST 16'h0F7F

`define SAWR_RST_NODE      16'h0000
`define SAWR_RST_ALIAS     16'h0000
`define SAWR_RST_BYTE      8'h00
`define SAWR_BIT_ENABLE    0

`define SAWR_SEQ_BYTE1     8'h52
`define SAWR_SEQ_BYTE2     8'h45
`define SAWR_SEQ_BYTE3     8'h53

`define SAWR_PRG_IDLE      2'b00
`define SAWR_PRG_ONE       2'b01
`define SAWR_PRG_TWO       2'b10

`endif

// *** tb/sawr_station_regs_properties.sv ***
// assertion checker for the station address and protection bank
`timescale 1ns/1ps
`default_nettype none
module sawr_station_regs_properties #(
  parameter AW = 16
) (
  input wire logic          clk_sys,
  input wire logic          rstn,
  input wire logic          net_wr,
  input wire logic          net_rd,
  input wire logic [AW-1:0] net_addr,
  input wire logic [7:0]    net_wdata,
  input wire logic [7:0]    net_rdata,
  input wire logic          net_wr_ok,
  input wire logic          net_wr_refused,
  input wire logic          cmd_valid,
  input wire logic          cmd_match,
  input wire logic          reset_req,
  input wire logic          reg_protect_bit,
  input wire logic          device_protect_bit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ack_follows_wr_a: assert property (net_wr |=> net_wr_ok != net_wr_refused)
    else $error("write got no single answer");
  no_stray_ack_a: assert property (!net_wr |=> !(net_wr_ok || net_wr_refused))
    else $error("answer without a write");
  dev_enable_open_a: assert property (net_wr && net_addr == 16'h0030 |=> net_wr_ok)
    else $error("device enable write refused");
  reg_enable_open_a: assert property (
    net_wr && net_addr == 16'h0020 && !device_protect_bit |=> net_wr_ok)
    else $error("register enable write refused");
  area_end_open_a: assert property (
    net_wr && net_addr > 16'h0F7F && !device_protect_bit |=> net_wr_ok)
    else $error("write past protected area refused");
  unprotected_open_a: assert property (
    net_wr && !reg_protect_bit && !device_protect_bit |=> net_wr_ok)
    else $error("write refused with protection off");
  reset_single_a: assert property (reset_req |=> !reset_req)
    else $error("reset request longer than one cycle");
  reset_cause_a: assert property (
    reset_req |-> $past(net_wr && net_addr == 16'h0040 && net_wdata == 8'h53))
    else $error("reset request without final byte");
  match_cause_a: assert property (cmd_match |-> $past(cmd_valid))
    else $error("match without command");
  rdata_idle_a: assert property (!net_rd |=> net_rdata == 8'h00)
    else $error("read data not idle");
  cover property (net_wr_refused);
  cover property (reset_req);
  cover property (cmd_match);
endmodule // sawr_station_regs_properties
bind sawr_station_regs sawr_station_regs_properties #(.AW(AW)) chk_u (.clk_sys, .rstn,
  .net_wr, .net_rd, .net_addr, .net_wdata, .net_rdata, .net_wr_ok, .net_wr_refused,
  .cmd_valid, .cmd_match, .reset_req, .reg_protect_bit, .device_protect_bit);
`default_nettype wire

// *** tb/sawr_net_master.sv ***
// network master model: frame starts and byte accesses
`timescale 1ns/1ps
`default_nettype none
module sawr_net_master (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  net_rdata,
  input  wire logic        net_wr_ok,
  input  wire logic        net_wr_refused,
  output logic             sof,
  output logic             net_wr,
  output logic             net_rd,
  output logic [15:0]      net_addr,
  output logic [7:0]       net_wdata
);
  initial {sof, net_wr, net_rd, net_addr, net_wdata} = '0;
  task automatic frame;
    @(negedge clk_sys) sof = 1'b1;
    @(negedge clk_sys) sof = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v, output logic [1:0] st);
    @(negedge clk_sys) {net_wr, net_addr, net_wdata} = {1'b1, a, v};
    @(negedge clk_sys) net_wr = 1'b0;
    st = {net_wr_ok, net_wr_refused};
    {net_addr, net_wdata} = ~{a, v}; // released lines show no stale value
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys) {net_rd, net_addr} = {1'b1, a};
    @(negedge clk_sys) net_rd = 1'b0;
    d = net_rdata;
    net_addr = ~a;
  endtask
endmodule // sawr_net_master
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the station address and protection bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, rstn = 0, alias_en = 0, host_wr = 0, host_rd = 0, nvm_load = 0;
  logic cmd_valid = 0, sof, net_wr, net_rd, net_wr_ok, net_wr_refused, cmd_match;
  logic reset_req, reg_protect_bit, device_protect_bit, b, rr;
  logic [15:0] host_addr = 0, nvm_alias = 0, cmd_addr = 0, net_addr, wen;
  logic [7:0]  host_wdata = 0, host_rdata, net_wdata, net_rdata, d;
  logic [1:0]  st;
  int          miscompares = 0, check_count = 0;
  logic [15:0] ofs[10] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0020, 16'h0021,
                           16'h0030, 16'h0031, 16'h0040, 16'h0050};
  logic [7:0]  seq[3] = '{8'h52, 8'h45, 8'h53};
  logic [7:0]  prg[3] = '{8'h01, 8'h02, 8'h00};
  always #5 clk_sys = ~clk_sys;
  sawr_station_regs #(.AW(16)) dut_u (.clk_sys, .rstn, .sof, .alias_en, .net_wr, .net_rd,
    .net_addr, .net_wdata, .net_rdata, .net_wr_ok, .net_wr_refused, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .nvm_load, .nvm_alias, .cmd_valid, .cmd_addr,
    .cmd_match, .reset_req, .reg_protect_bit, .device_protect_bit);
  sawr_net_master m_u (.clk_sys, .net_rdata, .net_wr_ok, .net_wr_refused, .sof, .net_wr,
    .net_rd, .net_addr, .net_wdata);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hacc(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_sys) {host_wr, host_rd, host_addr, host_wdata} = {w, !w, a, v};
    @(negedge clk_sys) {host_wr, host_rd} = 2'b00;
    d = host_rdata;
  endtask
  task automatic match(input logic [15:0] a);
    @(negedge clk_sys) {cmd_valid, cmd_addr} = {1'b1, a};
    @(negedge clk_sys) cmd_valid = 1'b0;
    b = cmd_match;
  endtask
  task automatic nvm(input logic [15:0] v);
    @(negedge clk_sys) {nvm_load, nvm_alias} = {1'b1, v};
    @(negedge clk_sys) nvm_load = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    foreach (ofs[i]) begin
      m_u.rd(ofs[i], d);
      chk(d, 8'h00);
    end
    m_u.wr(16'h0010, 8'h34, st);
    m_u.wr(16'h0011, 8'h12, st);
    hacc(1, 16'h0010, 8'hff);
    hacc(0, 16'h0010, 8'h00);
    chk(d, 8'h34);
    match(16'h1234);
    chk(b, 1);
    nvm(16'h5678);
    nvm(16'h1111);
    m_u.wr(16'h0012, 8'h00, st);
    m_u.rd(16'h0012, d);
    chk(d, 8'h78);
    match(16'h5678);
    chk(b, 0);
    @(negedge clk_sys) alias_en = 1'b1;
    match(16'h5678);
    chk(b, 1);
    hacc(1, 16'h0013, 8'h9a);
    m_u.rd(16'h0013, d);
    chk(d, 8'h9a);
    for (int i = 0; i < 2; i++) begin
      wen = i ? 16'h0030 : 16'h0020;
      m_u.wr({wen[15:4], 4'h1}, 8'h01, st);
      chk({7'h00, i ? device_protect_bit : reg_protect_bit}, 8'h01);
      m_u.frame;
      m_u.wr(16'h0010, 8'ha5, st);
      chk(st, 2'b01);
      m_u.rd(16'h0010, d);
      chk(d, 8'h34);
      m_u.wr(16'h0F80, 8'h00, st);
      chk(st, i ? 2'b01 : 2'b10);
      m_u.wr(wen, 8'h00, st);
      m_u.wr(16'h0010, 8'h34, st);
      chk(st, 2'b10);
      m_u.rd(wen, d);
      chk(d, 8'h01);
      m_u.frame;
      m_u.rd(wen, d);
      chk(d, 8'h00);
      m_u.wr(wen, 8'h00, st);
      m_u.wr({wen[15:4], 4'h1}, 8'h00, st);
      chk({7'h00, i ? device_protect_bit : reg_protect_bit}, 8'h00);
      m_u.rd(wen, d);
      chk(d, 8'h00);
    end
    m_u.frame;
    m_u.wr(16'h0040, 8'h52, st);
    m_u.frame;
    m_u.wr(16'h0040, 8'h52, st);
    m_u.rd(16'h0040, d);
    chk(d, 8'h00);
    for (int k = 0; k < 3; k++) begin
      m_u.frame;
      m_u.wr(16'h0040, seq[k], st);
      rr = reset_req;
      m_u.rd(16'h0040, d);
      chk(d, prg[k]);
      chk({7'h00, rr}, {7'h00, k == 2});
    end
    @(negedge clk_sys) rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    nvm(16'h2222);
    m_u.rd(16'h0012, d);
    chk(d, 8'h22);
    m_u.rd(16'h0010, d);
    chk(d, 8'h00);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
